// ---- hdl/tcb_pkg.sv ----
/*
 * constants and types shared by the time-code transmitter files.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package tcb_pkg;
	// register byte offsets inside the window
	localparam logic [15:0] OFF_CTRL = 16'h0000;
	localparam logic [15:0] OFF_STAT = 16'h0004;
	localparam logic [15:0] OFF_VER = 16'h000C;
	localparam logic [15:0] OFF_CORR = 16'h0010;
	localparam logic [31:0] REG_SPAN = 32'h0000FFFF;
	// version word, value is arbitrary
	localparam logic [31:0] VERSION_VAL = 32'h01000000;
	// reset values
	localparam logic CTRL_RST = 1'h0;
	localparam logic [31:0] CORR_RST = 32'h00000000;
	// parameter defaults
	localparam int DEF_CLK_PERIOD_NS = 20;
	localparam int DEF_OUT_DELAY_NS = 0;
	// time arithmetic
	localparam logic [31:0] NS_PER_SEC = 32'h3B9ACA00;
	localparam logic [31:0] SEC_PER_MIN = 32'h0000003C;
	localparam logic [31:0] SEC_PER_HOUR = 32'h00000E10;
	localparam logic [31:0] SEC_PER_DAY = 32'h00015180;
	localparam logic [11:0] EPOCH_YEAR = 12'h7B2;
	localparam logic [15:0] EPOCH_WDAY_OFS = 16'h0003;
	// pulse widths in milliseconds, sim divider
	localparam int PULSE_ZERO_MS = 100;
	localparam int PULSE_ONE_MS = 200;
	localparam int SIM_DIV = 10;
	// frame layout, second 59 carries no pulse
	localparam logic [5:0] MARK_SEC = 6'h3B;
	localparam int FB_START = 20;
	localparam int FB_MIN = 21;
	localparam int FB_PMIN = 28;
	localparam int FB_HOUR = 29;
	localparam int FB_PHOUR = 35;
	localparam int FB_MDAY = 36;
	localparam int FB_WDAY = 42;
	localparam int FB_MON = 45;
	localparam int FB_YEAR = 50;
	localparam int FB_PDATE = 58;
	// core state info bits
	localparam int INFO_EN = 0;
	localparam int INFO_ERR = 1;
	localparam int INFO_RUN = 2;
	localparam int INFO_TVAL = 3;
	typedef enum logic [1:0] {TX_IDLE, TX_WAIT_MIN, TX_RUN} tcb_tx_t;
	typedef enum logic [1:0] {CV_IDLE, CV_YEAR, CV_MONTH} tcb_cv_t;
endpackage

// ---- hdl/tcb_time_conv.sv ----
/*
 * seconds since 1970 to calendar time of day converter.
 * assumes a start pulse only while idle; result is ready within about 160 cycles.
 */
`timescale 1ns/100ps
module tcb_time_conv (
	// system
	input wire logic pclk,
	input wire logic presetn,
	// request
	input wire logic start,
	input wire logic [31:0] utc_sec,
	// result
	output logic done,
	output logic [5:0] minute,
	output logic [4:0] hour,
	output logic [4:0] mday,
	output logic [2:0] wday,
	output logic [3:0] month,
	output logic [11:0] year
);
	typedef struct packed {
		tcb_pkg::tcb_cv_t fsm;
		logic [15:0] days;
		logic [11:0] year;
		logic [3:0] month;
		logic [4:0] mday;
		logic [5:0] minute;
		logic [4:0] hour;
		logic [2:0] wday;
		logic done;
	} tcb_conv_t;

	tcb_conv_t st, next_st;
	logic leap;
	logic [8:0] ylen;
	logic [4:0] mlen;
	logic [31:0] sod;
	logic [15:0] day_cnt;

	// leap year and month lengths of the year being walked
	assign leap = (st.year[1:0] == 2'h0) && ((st.year % 12'h064 != 12'h000) || (st.year % 12'h190 == 12'h000));
	assign ylen = leap ? 9'h16E : 9'h16D;
	assign sod = utc_sec % tcb_pkg::SEC_PER_DAY;
	assign day_cnt = 16'(utc_sec / tcb_pkg::SEC_PER_DAY);
	always_comb begin
		case (st.month)
			4'h2: mlen = leap ? 5'h1D : 5'h1C;
			4'h4, 4'h6, 4'h9, 4'hB: mlen = 5'h1E;
			default: mlen = 5'h1F;
		endcase
	end

	// split time of day at once, then walk years and months
	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		case (st.fsm)
			tcb_pkg::CV_IDLE: begin
				if (start) begin
					next_st.days = day_cnt;
					next_st.minute = 6'((sod / tcb_pkg::SEC_PER_MIN) % tcb_pkg::SEC_PER_MIN);
					next_st.hour = 5'(sod / tcb_pkg::SEC_PER_HOUR);
					next_st.wday = 3'(((day_cnt + tcb_pkg::EPOCH_WDAY_OFS) % 16'h0007) + 16'h0001);
					next_st.year = tcb_pkg::EPOCH_YEAR;
					next_st.month = 4'h1;
					next_st.fsm = tcb_pkg::CV_YEAR;
				end
			end
			tcb_pkg::CV_YEAR: begin
				if (st.days >= {7'h00, ylen}) begin
					next_st.days = st.days - {7'h00, ylen};
					next_st.year = st.year + 12'h001;
				end else begin
					next_st.fsm = tcb_pkg::CV_MONTH;
				end
			end
			tcb_pkg::CV_MONTH: begin
				if (st.days >= {11'h000, mlen}) begin
					next_st.days = st.days - {11'h000, mlen};
					next_st.month = st.month + 4'h1;
				end else begin
					next_st.mday = 5'(st.days + 16'h0001);
					next_st.done = 1'b1;
					next_st.fsm = tcb_pkg::CV_IDLE;
				end
			end
			default: next_st.fsm = tcb_pkg::CV_IDLE;
		endcase
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign done = st.done;
	assign minute = st.minute;
	assign hour = st.hour;
	assign mday = st.mday;
	assign wday = st.wday;
	assign month = st.month;
	assign year = st.year;
endmodule

// ---- hdl/tcb_top.sv ----
/*
 * time-code transmitter top: apb register slave or static configuration,
 * seconds correction, calendar conversion, bcd frame and pulse-width output.
 * assumes clock time, milli tick and static inputs synchronous to pclk,
 * and an external driver adding out_delay_ns_param to the output.
 */
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps
// Functional notes
// [RULE_01] all parameters are fixed when the core is built
// [RULE_02] clock period parameter in whole ns, default 20 ns for 50 MHz
// [RULE_03] output edges are advanced by the configured output path delay
// [RULE_04] registers answer from base address up to limit, default base plus FFFF
// [RULE_05] simulation parameter true selects test behaviour, false synthesis
// [RULE_06] time value holds seconds, nanoseconds, fraction, sign and step marker
// [RULE_07] sign bit one means negative time, zero positive
// [RULE_08] time source marks every discontinuous clock step
// [RULE_09] add correction, convert to utc calendar, bcd encode, send pulse code
// [RULE_10] second boundaries of the stream sit exactly on the reference mark
// [RULE_11] build switch picks static input configuration or register configuration
// [RULE_12] in register mode a bus master configures by writing registers
// [RULE_13] static configuration carries a correction time value
// [RULE_14] static valid carries the enable flag that starts the transmitter
// [RULE_15] core outputs state info with a separate valid flag
// [RULE_16] time source gives time, valid qualifier and a millisecond tick
// [RULE_17] output is held low while the core is disabled
// [RULE_18] on a step stop, drive low, flag error, restart at next minute
// [RULE_19] bus master uses aligned single word accesses only
// [RULE_20] static enable comes last; changes need disable then enable
// [RULE_21] active low reset holds output low and clears state
module tcb_top #(
	parameter bit static_cfg_select = 1'b0,
	parameter int clk_period_ns_param = tcb_pkg::DEF_CLK_PERIOD_NS,
	parameter int out_delay_ns_param = tcb_pkg::DEF_OUT_DELAY_NS,
	parameter logic [31:0] reg_base_addr = 32'h00000000,
	parameter logic [31:0] reg_limit_addr = reg_base_addr + tcb_pkg::REG_SPAN,
	parameter bit sim_mode = 1'b0
) (
	// system
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// time input
	input wire logic milli_tick_in,
	input wire logic [31:0] clock_time_sec_in,
	input wire logic [31:0] clock_time_ns_in,
	input wire logic [1:0] clock_time_frac_in,
	input wire logic clock_time_sign_in,
	input wire logic clock_time_step_in,
	input wire logic clock_time_valid_in,
	// static configuration
	input wire logic [31:0] static_cfg_sec_in,
	input wire logic [31:0] static_cfg_ns_in,
	input wire logic [1:0] static_cfg_frac_in,
	input wire logic static_cfg_sign_in,
	input wire logic static_cfg_step_in,
	input wire logic static_cfg_valid_in,
	// static status
	output logic [7:0] static_stat_out,
	output logic static_stat_valid_out,
	// time-code output
	output logic timecode_out,
	output logic timecode_error_out
);
	// output advance covers the driver delay plus one pipeline cycle
	localparam logic [32:0] ADV_NS = 33'(out_delay_ns_param + clk_period_ns_param); // [RULE_03] [RULE_02]
	// shorter pulses keep simulations brief
	localparam logic [7:0] W_ZERO = sim_mode ? 8'(tcb_pkg::PULSE_ZERO_MS / tcb_pkg::SIM_DIV) :
		8'(tcb_pkg::PULSE_ZERO_MS); // [RULE_05]
	localparam logic [7:0] W_ONE = sim_mode ? 8'(tcb_pkg::PULSE_ONE_MS / tcb_pkg::SIM_DIV) :
		8'(tcb_pkg::PULSE_ONE_MS); // [RULE_05]

	typedef struct packed {
		logic ack;
		logic [31:0] prdata;
		logic slverr;
		logic ctrl_en;
		logic cfg_en;
		logic err;
		logic cor_sign;
		logic [30:0] cor_sec;
		logic [31:0] prev_sec;
		logic prev_valid;
		tcb_pkg::tcb_tx_t mode;
		logic [7:0] ms_cnt;
		logic [7:0] pw;
		logic [58:0] frame;
		logic conv_start;
		logic [31:0] conv_sec;
		logic tc;
		logic eout;
		logic [7:0] info;
		logic info_val;
	} tcb_state_t;

	tcb_state_t st, next_st;
	logic access, in_win, mapped;
	logic [15:0] off;
	logic [31:0] rd_val;
	logic enable;
	logic time_ok;
	logic [32:0] ns_sum;
	logic [31:0] adv_sec, utc_sec;
	logic [5:0] som;
	logic boundary;
	logic cv_done;
	logic [5:0] cv_min;
	logic [4:0] cv_hour, cv_mday;
	logic [2:0] cv_wday;
	logic [3:0] cv_mon;
	logic [11:0] cv_year;
	logic [58:0] new_frame;
	logic [7:0] bcd_min, bcd_hour, bcd_mday, bcd_mon, bcd_year;

	// two-digit bcd of a binary value below 100
	function automatic logic [7:0] to_bcd(input logic [7:0] v);
		logic [7:0] tens;
		tens = v / 8'h0A;
		return {tens[3:0], 4'(v - tens * 8'h0A)};
	endfunction

	// register window decode
	assign access = psel & penable;
	assign in_win = (paddr >= reg_base_addr) && (paddr <= reg_limit_addr); // [RULE_04]
	assign off = 16'(paddr - reg_base_addr);
	assign mapped = in_win && (off == tcb_pkg::OFF_CTRL || off == tcb_pkg::OFF_STAT ||
		off == tcb_pkg::OFF_VER || off == tcb_pkg::OFF_CORR); // [RULE_19]

	// read multiplexer
	always_comb begin
		case (off)
			tcb_pkg::OFF_CTRL: rd_val = {31'h00000000, enable};
			tcb_pkg::OFF_STAT: rd_val = {31'h00000000, st.err};
			tcb_pkg::OFF_VER: rd_val = tcb_pkg::VERSION_VAL;
			tcb_pkg::OFF_CORR: rd_val = {st.cor_sign, st.cor_sec};
			default: rd_val = 32'h00000000;
		endcase
	end

	// configuration source chosen when the core is built
	assign enable = static_cfg_select ? st.cfg_en : st.ctrl_en; // [RULE_11] [RULE_01]

	// time input with output delay compensation
	assign time_ok = clock_time_valid_in & ~clock_time_sign_in; // [RULE_16] [RULE_07]
	assign ns_sum = {1'b0, clock_time_ns_in} + ADV_NS; // [RULE_03]
	assign adv_sec = clock_time_sec_in + {31'h00000000, ns_sum >= {1'b0, tcb_pkg::NS_PER_SEC}}; // [RULE_03]
	// correction added or taken off by its sign
	assign utc_sec = st.cor_sign ? adv_sec - {1'b0, st.cor_sec} : adv_sec + {1'b0, st.cor_sec}; // [RULE_09] [RULE_07]
	assign som = 6'(utc_sec % tcb_pkg::SEC_PER_MIN);
	assign boundary = time_ok & st.prev_valid & (adv_sec != st.prev_sec); // [RULE_10]

	// calendar conversion of the minute to be announced
	tcb_time_conv u_conv (
		.pclk(pclk),
		.presetn(presetn),
		.start(st.conv_start),
		.utc_sec(st.conv_sec),
		.done(cv_done),
		.minute(cv_min),
		.hour(cv_hour),
		.mday(cv_mday),
		.wday(cv_wday),
		.month(cv_mon),
		.year(cv_year)
	);

	// bcd digits of the converted time
	assign bcd_min = to_bcd({2'h0, cv_min}); // [RULE_09]
	assign bcd_hour = to_bcd({3'h0, cv_hour});
	assign bcd_mday = to_bcd({3'h0, cv_mday});
	assign bcd_mon = to_bcd({4'h0, cv_mon});
	assign bcd_year = to_bcd(8'(cv_year % 12'h064));

	// frame of one minute with even parity over each group
	always_comb begin
		new_frame = '0;
		new_frame[tcb_pkg::FB_START] = 1'b1;
		new_frame[tcb_pkg::FB_MIN +: 7] = bcd_min[6:0]; // [RULE_09]
		new_frame[tcb_pkg::FB_PMIN] = ^bcd_min[6:0];
		new_frame[tcb_pkg::FB_HOUR +: 6] = bcd_hour[5:0];
		new_frame[tcb_pkg::FB_PHOUR] = ^bcd_hour[5:0];
		new_frame[tcb_pkg::FB_MDAY +: 6] = bcd_mday[5:0];
		new_frame[tcb_pkg::FB_WDAY +: 3] = cv_wday;
		new_frame[tcb_pkg::FB_MON +: 5] = bcd_mon[4:0];
		new_frame[tcb_pkg::FB_YEAR +: 8] = bcd_year;
		new_frame[tcb_pkg::FB_PDATE] = ^{bcd_mday[5:0], cv_wday, bcd_mon[4:0], bcd_year};
	end

	// next state of the whole core
	always_comb begin
		next_st = st;
		next_st.conv_start = 1'b0;
		// apb: one wait state, data registered for the completing edge
		next_st.ack = access & ~st.ack;
		if (access && !st.ack) begin
			next_st.prdata = mapped && !pwrite ? rd_val : 32'h00000000;
			next_st.slverr = ~mapped;
		end
		if (access && st.ack && pwrite && mapped) begin
			// writes land only in register mode, status clears in both
			if (off == tcb_pkg::OFF_CTRL && !static_cfg_select) begin
				next_st.ctrl_en = pwdata[0]; // [RULE_12]
			end
			if (off == tcb_pkg::OFF_CORR && !static_cfg_select) begin
				next_st.cor_sign = pwdata[31];
				next_st.cor_sec = pwdata[30:0];
			end
			if (off == tcb_pkg::OFF_STAT && pwdata[0]) begin
				next_st.err = 1'b0;
			end
		end
		// static mode: correction taken when enable rises
		next_st.cfg_en = static_cfg_valid_in; // [RULE_14]
		if (static_cfg_select && static_cfg_valid_in && !st.cfg_en) begin
			next_st.cor_sign = static_cfg_sign_in; // [RULE_13] [RULE_20]
			next_st.cor_sec = static_cfg_sec_in[30:0];
		end
		// second tracking
		next_st.prev_valid = time_ok;
		if (time_ok) begin
			next_st.prev_sec = adv_sec;
		end
		// pulse ends after its width in milliseconds
		if (st.tc && milli_tick_in) begin
			next_st.ms_cnt = st.ms_cnt + 8'h01;
			if (st.ms_cnt + 8'h01 >= st.pw) begin
				next_st.tc = 1'b0;
			end
		end
		if (cv_done) begin
			next_st.frame = new_frame;
		end
		// transmitter sequence
		case (st.mode)
			tcb_pkg::TX_IDLE: begin
				next_st.tc = 1'b0; // [RULE_17]
				if (enable) begin
					next_st.mode = tcb_pkg::TX_WAIT_MIN;
				end
			end
			tcb_pkg::TX_WAIT_MIN: begin
				next_st.tc = 1'b0;
				if (boundary && som == 6'h00) begin
					next_st.mode = tcb_pkg::TX_RUN; // [RULE_18]
					next_st.eout = 1'b0;
					next_st.conv_start = 1'b1;
					next_st.conv_sec = utc_sec + tcb_pkg::SEC_PER_MIN;
					next_st.tc = 1'b1; // [RULE_10]
					next_st.ms_cnt = 8'h00;
					next_st.pw = W_ZERO;
				end
			end
			tcb_pkg::TX_RUN: begin
				if (boundary) begin
					next_st.ms_cnt = 8'h00;
					next_st.tc = som != tcb_pkg::MARK_SEC; // [RULE_10]
					next_st.pw = st.frame[som] ? W_ONE : W_ZERO; // [RULE_09]
					if (som == 6'h00) begin
						next_st.conv_start = 1'b1;
						next_st.conv_sec = utc_sec + tcb_pkg::SEC_PER_MIN;
						next_st.pw = W_ZERO;
					end
				end
			end
			default: next_st.mode = tcb_pkg::TX_IDLE;
		endcase
		// a clock step stops the stream at once; set wins over clear
		if (st.mode != tcb_pkg::TX_IDLE && clock_time_valid_in && clock_time_step_in) begin
			next_st.mode = tcb_pkg::TX_WAIT_MIN; // [RULE_18] [RULE_08]
			next_st.tc = 1'b0;
			next_st.eout = 1'b1;
			next_st.err = 1'b1;
		end
		// disabling overrides everything except the error flag and parks the output low
		if (!enable) begin
			next_st.mode = tcb_pkg::TX_IDLE; // [RULE_17]
			next_st.tc = 1'b0;
			next_st.eout = 1'b0;
		end
		// core state info
		next_st.info = 8'h00;
		next_st.info[tcb_pkg::INFO_EN] = enable; // [RULE_15]
		next_st.info[tcb_pkg::INFO_ERR] = st.err;
		next_st.info[tcb_pkg::INFO_RUN] = st.mode == tcb_pkg::TX_RUN;
		next_st.info[tcb_pkg::INFO_TVAL] = time_ok;
		next_st.info_val = 1'b1;
	end

	// state register, cleared by reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0; // [RULE_21]
			st.ctrl_en <= tcb_pkg::CTRL_RST;
			st.cor_sign <= tcb_pkg::CORR_RST[31];
			st.cor_sec <= tcb_pkg::CORR_RST[30:0];
			st.mode <= tcb_pkg::TX_IDLE;
		end else begin
			st <= next_st;
		end
	end

	// outputs
	assign pready = access & st.ack;
	assign prdata = st.prdata;
	assign pslverr = st.slverr & access & st.ack;
	assign static_stat_out = st.info; // [RULE_15]
	assign static_stat_valid_out = st.info_val;
	assign timecode_out = st.tc; // [RULE_21]
	assign timecode_error_out = st.eout;
endmodule

// ---- tb/tcb_props.sv ----
/*
 * port assertions for tcb_top: apb answers, reset, status and the output line.
 * assumes binding to every tcb_top instance, one clock domain.
 */
`timescale 1ns/100ps
module tcb_props #(
	parameter int clk_period_ns_param = 20,
	parameter int out_delay_ns_param = 0,
	parameter logic [31:0] reg_base_addr = 32'h00000000,
	parameter logic [31:0] reg_limit_addr = 32'h0000FFFF
) (
	// system
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// time input
	input wire logic [31:0] clock_time_ns_in,
	input wire logic clock_time_sign_in,
	input wire logic clock_time_step_in,
	input wire logic clock_time_valid_in,
	// status and line
	input wire logic [7:0] static_stat_out,
	input wire logic static_stat_valid_out,
	input wire logic timecode_out,
	input wire logic timecode_error_out
);
	localparam logic [63:0] ADV = 64'(clk_period_ns_param) + 64'(out_delay_ns_param);
	logic [31:0] off;
	logic legal;
	logic en;
	// offset decode inside the window and the enable seen on the status
	assign off = paddr - reg_base_addr;
	assign legal = paddr >= reg_base_addr && paddr <= reg_limit_addr && off inside {32'h0, 32'h4, 32'hC, 32'h10};
	assign en = static_stat_out[tcb_pkg::INFO_EN];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_reset_clears: assert property ($rose(presetn) |-> !timecode_out && !timecode_error_out && !static_stat_valid_out)
		else $error("outputs not cleared by reset");
	a_stat_valid: assert property ($past(presetn) |-> static_stat_valid_out)
		else $error("status valid missing");
	a_ready_wait: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	a_ready_gate: assert property (pready |-> psel && penable)
		else $error("ready outside an access");
	a_window_err: assert property (pready |-> pslverr == !legal)
		else $error("error answer does not match the address window");
	a_err_data: assert property (pready && (pslverr || pwrite) |-> prdata == 32'h0)
		else $error("read data not zero");
	a_tval_sign: assert property (static_stat_out[tcb_pkg::INFO_TVAL] == $past(clock_time_valid_in && !clock_time_sign_in))
		else $error("time valid status wrong");
	a_disabled_low: assert property (!en [*2] |-> !timecode_out)
		else $error("line high while disabled");
	a_step_stop: assert property (clock_time_valid_in && clock_time_step_in && !clock_time_sign_in && en |=>
		!timecode_out && timecode_error_out)
		else $error("step did not stop the line");
	a_mark_align: assert property ($rose(timecode_out) |-> 64'($past(clock_time_ns_in)) + ADV >= 64'h3B9ACA00 &&
		64'($past(clock_time_ns_in, 2)) + ADV < 64'h3B9ACA00)
		else $error("pulse start off the advanced second");
	// main scenarios reached
	c_refused: cover property (pready && pslverr);
	c_write: cover property (pready && pwrite && !pslverr);
	c_pulse: cover property ($rose(timecode_out));
	c_step: cover property ($rose(timecode_error_out));
endmodule

bind tcb_top tcb_props #(.clk_period_ns_param(clk_period_ns_param), .out_delay_ns_param(out_delay_ns_param),
	.reg_base_addr(reg_base_addr), .reg_limit_addr(reg_limit_addr)) u_props (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .clock_time_ns_in, .clock_time_sign_in, .clock_time_step_in,
	.clock_time_valid_in, .static_stat_out, .static_stat_valid_out, .timecode_out, .timecode_error_out);

// ---- tb/tcb_rx_model.sv ----
/*
 * receiver on the far side of the line: measures pulses in milli ticks.
 * assumes one milli tick input shared with the transmitter.
 */
`timescale 1ns/100ps
module tcb_rx_model (
	// system
	input wire logic pclk,
	input wire logic milli_tick_in,
	// line
	input wire logic timecode_out,
	// decoded
	output logic [59:0] frame_bits,
	output int n_pulses,
	output int gap_last,
	output int bad_width
);
	int ticks = 0;
	int cyc = 0;
	int last_rise = 0;
	logic line_q = 1'b0;
	initial begin
		frame_bits = '0;
		n_pulses = 0;
		gap_last = 0;
		bad_width = 0;
	end
	// short pulse is a zero, long pulse a one; odd widths are counted
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		line_q <= timecode_out;
		if (timecode_out && !line_q) begin
			gap_last <= cyc - last_rise;
			last_rise <= cyc;
			ticks <= 0;
		end else if (timecode_out && milli_tick_in) begin
			ticks <= ticks + 1;
		end
		if (!timecode_out && line_q) begin
			frame_bits[n_pulses % 60] <= ticks > 15;
			if (!(ticks inside {[8:12], [18:22]}))
				bad_width <= bad_width + 1;
			n_pulses <= n_pulses + 1;
		end
	end
endmodule

// ---- tb/tb_timecode_broadcast_top.sv ----
/*
 * bench for tcb_top: registers, one whole frame, step and disable, static twin.
 * assumes tcb_props bound to the design and tcb_rx_model on the line.
 */
`timescale 1ns/100ps
module tb_timecode_broadcast_top;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
	logic [31:0] paddr = 0, pwdata = 0, prdata, clock_time_sec_in = 0, clock_time_ns_in = 0, corr = 0;
	logic [31:0] static_cfg_sec_in = 0, static_cfg_ns_in = 0;
	logic [1:0] clock_time_frac_in = 0, static_cfg_frac_in = 0;
	logic milli_tick_in = 0, clock_time_sign_in = 0, clock_time_step_in = 0, clock_time_valid_in = 0;
	logic static_cfg_sign_in = 0, static_cfg_step_in = 0, static_cfg_valid_in = 0, feed = 0;
	logic [7:0] static_stat_out;
	logic static_stat_valid_out, timecode_out, timecode_error_out, tc_s;
	logic [59:0] bits;
	int n_errors = 0, num_checks = 0, n_diff = 0, npul, gap, badw, h, m, k;
	always #4 pclk = ~pclk;
	// time source: 1 ms of time and one milli tick per cycle
	always @(posedge pclk) begin
		milli_tick_in <= feed;
		// unused fields still move so that nothing behind them is tied
		clock_time_frac_in <= 2'($urandom);
		static_cfg_ns_in <= $urandom;
		static_cfg_frac_in <= 2'($urandom);
		static_cfg_step_in <= 1'($urandom);
		if (feed) begin
			clock_time_ns_in <= clock_time_ns_in == 32'h3B8B87C0 ? 32'h0 : clock_time_ns_in + 32'h000F4240;
			if (clock_time_ns_in == 32'h3B8B87C0)
				clock_time_sec_in <= clock_time_sec_in + 32'h1;
		end
	end
	// both builds must put out the same line
	always @(negedge pclk) if (timecode_out !== tc_s) n_diff++;
	tcb_top #(.clk_period_ns_param(32'h000F4240), .out_delay_ns_param(32'h001E8480), .sim_mode(1'b1)) dut (.*);
	tcb_top #(.static_cfg_select(1'b1), .clk_period_ns_param(32'h000F4240), .out_delay_ns_param(32'h001E8480),
		.sim_mode(1'b1)) dut_s (.*, .prdata(), .pready(), .pslverr(), .static_stat_out(), .static_stat_valid_out(),
		.timecode_out(tc_s),
		.timecode_error_out());
	tcb_rx_model rx (.pclk, .milli_tick_in, .timecode_out, .frame_bits(bits), .n_pulses(npul), .gap_last(gap),
		.bad_width(badw));
	function automatic logic [7:0] bcd(input int v);
		return 8'((v / 10) * 16 + v % 10);
	endfunction
	// frame of a minute on the first day of 1970, a thursday
	function automatic logic [58:0] exp_frame(input int hh, input int mm);
		logic [58:0] f;
		f = '0;
		f[20] = 1'b1;
		f[27:21] = 7'(bcd(mm));
		f[28] = ^f[27:21];
		f[34:29] = 6'(bcd(hh));
		f[35] = ^f[34:29];
		f[41:36] = 6'h01;
		f[44:42] = 3'h4;
		f[49:45] = 5'h01;
		f[57:50] = bcd(70);
		f[58] = ^f[57:36];
		return f;
	endfunction
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	// one apb transfer, held until ready is seen
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d, input logic [31:0] exp,
		input logic err);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// answer is taken at the rising edge where ready is seen high
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		check(pready, 1'b1);
		check(pslverr, err);
		check(prdata, exp);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge pclk);
		n_errors++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'hF4A4));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		clock_time_valid_in <= 1'b1;
		clock_time_sign_in <= 1'b1;
		apb(0, 32'(tcb_pkg::OFF_CTRL), 0, 0, 0);
		apb(0, 32'(tcb_pkg::OFF_STAT), 0, 0, 0);
		apb(0, 32'(tcb_pkg::OFF_VER), 0, tcb_pkg::VERSION_VAL, 0);
		apb(0, 32'(tcb_pkg::OFF_CORR), 0, 0, 0);
		check(static_stat_valid_out, 1'b1);
		check(static_stat_out[tcb_pkg::INFO_TVAL], 1'b0);
		clock_time_sign_in <= 1'b0;
		repeat (2) @(negedge pclk);
		check(static_stat_out[tcb_pkg::INFO_TVAL], 1'b1);
		$display("test reset and sign done");
		apb(0, 32'h8, 0, 0, 1);
		apb(1, 32'h8, $urandom, 0, 1);
		apb(0, 32'h0000FFFC, 0, 0, 1);
		apb(0, 32'h00010000, 0, 0, 1);
		$display("test refusals done");
		corr = $urandom % 64;
		h = 1 + $urandom % 22;
		m = $urandom % 59;
		apb(1, 32'(tcb_pkg::OFF_CORR), {1'b1, corr[30:0]}, 0, 0);
		apb(0, 32'(tcb_pkg::OFF_CORR), 0, {1'b1, corr[30:0]}, 0);
		static_cfg_sec_in <= corr;
		static_cfg_sign_in <= 1'b1;
		apb(1, 32'(tcb_pkg::OFF_CTRL), 32'hFFFFFFFF, 0, 0);
		static_cfg_valid_in <= 1'b1;
		apb(0, 32'(tcb_pkg::OFF_CTRL), 0, 1, 0);
		check(static_stat_out[tcb_pkg::INFO_EN], 1'b1);
		$display("test config done");
		clock_time_sec_in <= 32'(h * 3600 + m * 60 - 3) + corr;
		clock_time_ns_in <= 32'h0;
		feed <= 1'b1;
		k = 0;
		while (npul < 60 && k < 66000) begin
			@(posedge pclk);
			k++;
		end
		check(bits[58:0], exp_frame(h, m + 1));
		check(gap, 2000);
		check(badw, 0);
		check(n_diff, 0);
		$display("test frame done");
		k = 0;
		while (timecode_out !== 1'b1 && k < 2000) begin
			@(posedge pclk);
			k++;
		end
		repeat (3) @(posedge pclk);
		clock_time_step_in <= 1'b1;
		@(posedge pclk);
		clock_time_step_in <= 1'b0;
		@(negedge pclk);
		check(timecode_out, 1'b0);
		check(timecode_error_out, 1'b1);
		apb(0, 32'(tcb_pkg::OFF_STAT), 0, 1, 0);
		apb(1, 32'(tcb_pkg::OFF_STAT), 1, 0, 0);
		apb(0, 32'(tcb_pkg::OFF_STAT), 0, 0, 0);
		k = npul;
		repeat (1500) @(posedge pclk);
		check(npul, k);
		check(timecode_error_out, 1'b1);
		$display("test step done");
		apb(1, 32'(tcb_pkg::OFF_CTRL), 0, 0, 0);
		static_cfg_valid_in <= 1'b0;
		apb(0, 32'(tcb_pkg::OFF_CTRL), 0, 0, 0);
		check(timecode_out, 1'b0);
		check(timecode_error_out, 1'b0);
		check(static_stat_out[tcb_pkg::INFO_EN], 1'b0);
		$display("test disable done");
		wrap_up();
	end
endmodule
